// [pkg/rtm_pkg.sv]
// constants and types for the output pin mux and oscillator trim block
// assumes a serial engine on core_clk that presents byte register accesses
// Operation
// [RQ1] square wave rate field picks divide ratio
// [RQ2] no square wave while on backup supply
// [RQ3] all rates trimmed except undivided rate
// [RQ4] alarms enabled, no square wave: interrupt
// [RQ5] alarm interrupt keeps working on backup
// [RQ6] one alarm: flag, inverted when polarity zero
// [RQ7] two alarms: OR, or inverted AND
// [RQ8] nothing enabled: pin follows level bit
// [RQ9] no general purpose level on backup
// [RQ10] fine trim applied once per minute
// [RQ11] sign bit: one adds, zero subtracts
// [RQ12] each step moves two oscillator pulses
// [RQ13] zero step count disables trimming
// [RQ14] trimming continues on backup supply
// [RQ15] coarse mode trims at 128 Hz, 64 Hz out
// [RQ16] square wave enable overrides alarm enables
// [RQ17] minute correction stretches or shrinks one second
package rtm_pkg;

    // register offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h07;
    localparam logic [7:0] TRIM_OFFSET = 8'h08;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // field positions
    localparam int CTRL_LEVEL_BIT = 7;
    localparam int CTRL_SQW_EN_BIT = 6;
    localparam int CTRL_ALM1_EN_BIT = 5;
    localparam int CTRL_ALM0_EN_BIT = 4;
    localparam int CTRL_EXTERNAL_CLOCK_INPUT_BIT = 3;
    localparam int CTRL_COARSE_BIT = 2;
    localparam int TRIM_SIGN_BIT = 7;

    // rate field encodings
    localparam logic [1:0] RATE_DIV_32768 = 2'h0;
    localparam logic [1:0] RATE_DIV_8 = 2'h1;
    localparam logic [1:0] RATE_DIV_4 = 2'h2;
    localparam logic [1:0] RATE_DIV_1 = 2'h3;

    // prescaler taps: bit n toggles at fosc / 2^(n+1)
    localparam int TAP_DIV_4 = 1;
    localparam int TAP_DIV_8 = 2;
    localparam int TAP_64HZ = 8;
    localparam int TAP_1HZ = 14;
    localparam int PRESCALE_BITS = 15;
    localparam int COARSE_BITS = 8;
    localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;

    // pin modes
    typedef enum logic [1:0] {
        RTM_MODE_GPO,
        RTM_MODE_ALARM,
        RTM_MODE_SQW
    } rtm_mode_t;

    typedef struct packed {
        logic level;
        logic square_wave_enable;
        logic alarm1En;
        logic alarm0En;
        logic external_clock_input;
        logic coarseTrim;
        logic [1:0] rateSelect;
    } rtm_ctrl_t;

    typedef struct packed {
        logic addCycles;
        logic [6:0] stepCount;
    } rtm_trim_t;

endpackage

// [design/rtm_pin_trim.sv]
// multi-function open-drain pin mux and digital oscillator trim
// assumes register accesses come from the serial engine on core_clk,
// oscillator and supply-state inputs arrive asynchronously from pins
`timescale 1ns/1ns

module rtm_pin_trim (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,

    // register access from the serial engine
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regHit,

    // oscillator and supply state pins
    input wire logic oscClkPin,
    input wire logic onBackupPin,

    // alarm state from the alarm comparators
    input wire logic alarm0MatchFlag,
    input wire logic alarm1MatchFlag,
    input wire logic alarmOutputPolarity,

    // oscillator source select
    output logic externalClockInput,

    // trimmed timebase
    output logic secondTick,
    output logic minuteTick,

    // multi-function pin, open drain
    output logic multiFunctionPinOut,
    output logic multiFunctionPinOe
);

    // synchronisers for pin inputs
    // the oscillator runs far below core_clk, so two flops settle it;
    // the third flop only keeps the last level for rising-edge detection
    // limitation: core_clk must be more than twice the oscillator rate,
    // or oscillator edges are lost and the timebase runs slow
    logic oscMeta_reg;
    logic oscSync_reg;
    logic oscPrev_reg;
    logic backupMeta_reg;
    logic backupSync_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oscMeta_reg <= 1'b0;
            oscSync_reg <= 1'b0;
            oscPrev_reg <= 1'b0;
            backupMeta_reg <= 1'b0;
            backupSync_reg <= 1'b0;
        end else begin
            oscMeta_reg <= oscClkPin;
            oscSync_reg <= oscMeta_reg;
            oscPrev_reg <= oscSync_reg;
            backupMeta_reg <= onBackupPin;
            backupSync_reg <= backupMeta_reg;
        end
    end

    wire logic oscEdge;
    wire logic onBackup;
    assign oscEdge = oscSync_reg & ~oscPrev_reg;
    assign onBackup = backupSync_reg;

    // register file
    // reset value has the level bit set, so the pin comes up released
    // and a host interrupt line sees no false assertion at power-on
    rtm_pkg::rtm_ctrl_t ctrl_reg;
    rtm_pkg::rtm_trim_t trim_reg;

    wire logic ctrlSel;
    wire logic trimSel;
    // serial port is dead on backup, so writes are dropped there
    wire logic writeAllowed;
    assign ctrlSel = (regAddr == rtm_pkg::CTRL_OFFSET);
    assign trimSel = (regAddr == rtm_pkg::TRIM_OFFSET);
    assign writeAllowed = regWrite & ~onBackup;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= rtm_pkg::rtm_ctrl_t'(rtm_pkg::CTRL_RESET);
            trim_reg <= rtm_pkg::rtm_trim_t'(rtm_pkg::TRIM_RESET);
        end else begin
            if (writeAllowed && ctrlSel) begin
                ctrl_reg <= rtm_pkg::rtm_ctrl_t'(regWrData);
            end
            if (writeAllowed && trimSel) begin
                trim_reg <= rtm_pkg::rtm_trim_t'(regWrData);
            end
        end
    end

    wire logic [7:0] rdMux;
    assign rdMux = ctrlSel ? 8'(ctrl_reg) : (trimSel ? 8'(trim_reg) : 8'h00);
    assign regHit = ctrlSel | trimSel;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= rdMux;
        end
    end

    assign externalClockInput = ctrl_reg.external_clock_input;

    // trimmed prescaler
    // add mode steps the counter by two for 2*step edges, so the corrected
    // period ends 2*step oscillator edges early; subtract mode holds the
    // counter for 2*step edges, so the period ends that many edges late
    // a subtract correction never spans a wrap: the longest, 254 edges, is shorter
    // than the 256-count coarse period; an add one of 254 edges steps 508 counts and spans a coarse wrap
    // correction is spread over the following oscillator edges instead of
    // jumping the counter, so the divided outputs never skip a phase
    logic [rtm_pkg::PRESCALE_BITS-1:0] prescale_reg;
    logic [rtm_pkg::PRESCALE_BITS-1:0] prescale_next;
    logic [5:0] seconds_reg;
    logic [5:0] seconds_next;
    logic [7:0] corrLeft_reg;
    logic [7:0] corrLeft_next;
    logic corrAdd_reg;
    logic corrAdd_next;
    logic secondTick_reg;
    logic minuteTick_reg;

    wire logic [1:0] stepSize;
    wire logic [rtm_pkg::PRESCALE_BITS:0] prescaleSum;
    wire logic [rtm_pkg::COARSE_BITS:0] coarseSum;
    wire logic secondWrap;
    wire logic coarseWrap;
    wire logic minuteWrap;
    wire logic correctionDue;
    wire logic [7:0] corrLoad;

    // while correcting, add mode steps by two and subtract mode holds
    assign stepSize = (corrLeft_reg == 8'h00) ? 2'h1 : (corrAdd_reg ? 2'h2 : 2'h0); // [RQ11]
    assign prescaleSum = {1'b0, prescale_reg} + (rtm_pkg::PRESCALE_BITS + 1)'(stepSize);
    assign coarseSum = {1'b0, prescale_reg[rtm_pkg::COARSE_BITS-1:0]} + (rtm_pkg::COARSE_BITS + 1)'(stepSize);
    assign secondWrap = oscEdge & prescaleSum[rtm_pkg::PRESCALE_BITS];
    assign coarseWrap = oscEdge & coarseSum[rtm_pkg::COARSE_BITS];
    assign minuteWrap = secondWrap & (seconds_reg == rtm_pkg::SECONDS_PER_MINUTE - 6'h01);
    // fine mode corrects at the minute, coarse mode at 128 Hz
    assign correctionDue = ctrl_reg.coarseTrim ? coarseWrap : minuteWrap; // [RQ10] [RQ15]
    assign corrLoad = {trim_reg.stepCount, 1'b0}; // [RQ12]

    always_comb begin
        prescale_next = prescale_reg;
        seconds_next = seconds_reg;
        corrLeft_next = corrLeft_reg;
        corrAdd_next = corrAdd_reg;
        if (oscEdge) begin
            prescale_next = prescaleSum[rtm_pkg::PRESCALE_BITS-1:0];
            if (corrLeft_reg != 8'h00) begin
                corrLeft_next = corrLeft_reg - 8'h01;
            end
            if (secondWrap) begin
                if (minuteWrap) begin
                    seconds_next = 6'h00;
                end else begin
                    seconds_next = seconds_reg + 6'h01;
                end
            end
            // a zero step count loads nothing, so no trimming happens
            if (correctionDue && trim_reg.stepCount != 7'h00) begin // [RQ13]
                corrLeft_next = corrLoad; // [RQ17]
                corrAdd_next = trim_reg.addCycles; // [RQ11]
            end
        end
    end

    // the trim state has no backup gating at all, so it keeps running there
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_reg <= '0;
            seconds_reg <= 6'h00;
            corrLeft_reg <= 8'h00;
            corrAdd_reg <= 1'b0;
            secondTick_reg <= 1'b0;
            minuteTick_reg <= 1'b0;
        end else begin
            prescale_reg <= prescale_next; // [RQ14]
            seconds_reg <= seconds_next;
            corrLeft_reg <= corrLeft_next;
            corrAdd_reg <= corrAdd_next;
            secondTick_reg <= secondWrap;
            minuteTick_reg <= minuteWrap;
        end
    end

    assign secondTick = secondTick_reg;
    assign minuteTick = minuteTick_reg;

    // square wave selection
    wire logic sqwTrimmed;
    wire logic sqwLevel;
    wire logic [3:0] tapBits;
    assign tapBits = {prescale_reg[rtm_pkg::TAP_1HZ], prescale_reg[rtm_pkg::TAP_DIV_8],
                      prescale_reg[rtm_pkg::TAP_DIV_4], prescale_reg[rtm_pkg::TAP_64HZ]};
    // rate field is ignored in coarse mode: output is the trimmed 64 Hz tap
    assign sqwTrimmed = ctrl_reg.coarseTrim ? tapBits[0] : // [RQ15]
                        (ctrl_reg.rateSelect == rtm_pkg::RATE_DIV_32768) ? tapBits[3] : // [RQ1]
                        (ctrl_reg.rateSelect == rtm_pkg::RATE_DIV_8) ? tapBits[2] : tapBits[1]; // [RQ1]
    // undivided rate taps the raw synchronised oscillator, bypassing trim
    assign sqwLevel = (!ctrl_reg.coarseTrim && ctrl_reg.rateSelect == rtm_pkg::RATE_DIV_1) ?
                      oscSync_reg : sqwTrimmed; // [RQ3]

    // alarm interrupt combination
    wire logic bothAlarms;
    wire logic singleFlag;
    wire logic alarmLevel;
    assign bothAlarms = ctrl_reg.alarm0En & ctrl_reg.alarm1En;
    assign singleFlag = ctrl_reg.alarm0En ? alarm0MatchFlag : alarm1MatchFlag;
    assign alarmLevel = bothAlarms ?
                        (alarmOutputPolarity ? (alarm0MatchFlag | alarm1MatchFlag) :
                         ~(alarm0MatchFlag & alarm1MatchFlag)) : // [RQ7]
                        (alarmOutputPolarity ? singleFlag : ~singleFlag); // [RQ6]

    // pin mode selection
    // square wave enable wins over both alarm enables; general purpose
    // output only when nothing else claims the pin
    rtm_pkg::rtm_mode_t pinMode;
    assign pinMode = ctrl_reg.square_wave_enable ? rtm_pkg::RTM_MODE_SQW : // [RQ16]
                     (ctrl_reg.alarm0En | ctrl_reg.alarm1En) ? rtm_pkg::RTM_MODE_ALARM : // [RQ4]
                     rtm_pkg::RTM_MODE_GPO; // [RQ8]

    logic pinLevel;
    always_comb begin
        pinLevel = 1'b1;
        case (pinMode)
            rtm_pkg::RTM_MODE_SQW: begin
                // released (pulled high) on backup
                pinLevel = onBackup ? 1'b1 : sqwLevel; // [RQ2]
            end
            rtm_pkg::RTM_MODE_ALARM: begin
                pinLevel = alarmLevel; // [RQ4] [RQ5]
            end
            default: begin
                pinLevel = onBackup ? 1'b1 : ctrl_reg.level; // [RQ8] [RQ9]
            end
        endcase
    end

    // open drain: only ever drive low; pin level registered to avoid glitches
    // the output enable is the only thing that moves; data stays low so the
    // pad never drives a high level against the pull-up
    // trade-off: one core cycle of latency on every pin change
    logic pinLow_reg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinLow_reg <= 1'b0;
        end else begin
            pinLow_reg <= ~pinLevel;
        end
    end

    assign multiFunctionPinOut = 1'b0;
    assign multiFunctionPinOe = pinLow_reg;

endmodule // rtm_pin_trim

// [bench/rtm_pin_trim_properties.sv]
// checker: register and pin relations of rtm_pin_trim
// assumes only the top ports; bound to every rtm_pin_trim below
`timescale 1ns/1ns
module rtm_pin_trim_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register access
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regHit,
    // pin causes
    input wire logic onBackupPin,
    input wire logic alarm0MatchFlag,
    input wire logic alarm1MatchFlag,
    input wire logic alarmOutputPolarity,
    // pin
    input wire logic multiFunctionPinOut,
    input wire logic multiFunctionPinOe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    logic [1:0] bkSync_reg;
    rtm_pkg::rtm_ctrl_t ctrl_reg;
    logic [7:0] trim_reg;
    // writes refused while on backup, as in the block
    wire logic wrOk = regWrite && !bkSync_reg[1];
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bkSync_reg <= 2'h0;
            ctrl_reg <= rtm_pkg::CTRL_RESET;
            trim_reg <= rtm_pkg::TRIM_RESET;
        end else begin
            bkSync_reg <= {bkSync_reg[0], onBackupPin};
            if (wrOk && regAddr == rtm_pkg::CTRL_OFFSET) ctrl_reg <= regWrData;
            if (wrOk && regAddr == rtm_pkg::TRIM_OFFSET) trim_reg <= regWrData;
        end
    end
    wire logic en0 = ctrl_reg.alarm0En;
    wire logic en1 = ctrl_reg.alarm1En;
    wire logic anyF = (en0 & alarm0MatchFlag) | (en1 & alarm1MatchFlag);
    wire logic allF = (!en0 | alarm0MatchFlag) & (!en1 | alarm1MatchFlag);
    wire logic almLevel = alarmOutputPolarity ? anyF : !allF;
    wire logic almOn = !ctrl_reg.square_wave_enable && (en0 || en1);
    wire logic gpoOn = !ctrl_reg.square_wave_enable && !en0 && !en1;

    sequence alm_cause_s;
        almOn ##1 1'b1;
    endsequence
    sequence gpo_cause_s;
        (gpoOn && bkSync_reg[0] == bkSync_reg[1]) ##1 1'b1;
    endsequence

    open_drain_a: assert property (!multiFunctionPinOut)
        else $error("pin data not held low");
    hit_decode_a: assert property (regHit == (regAddr == 8'h07 || regAddr == 8'h08))
        else $error("register hit decode wrong");
    unmapped_read_a: assert property ($past(reset_n) && !$past(regAddr == 8'h07 || regAddr == 8'h08)
        |-> regRdData == 8'h00) else $error("unmapped read not zero");
    ctrl_readback_a: assert property ($past(reset_n) && $past(regAddr) == rtm_pkg::CTRL_OFFSET
        |-> regRdData == $past(ctrl_reg)) else $error("control readback wrong");
    trim_readback_a: assert property ($past(reset_n) && $past(regAddr) == rtm_pkg::TRIM_OFFSET
        |-> regRdData == $past(trim_reg)) else $error("trim readback wrong");
    alarm_pin_a: assert property (alm_cause_s |-> multiFunctionPinOe == !$past(almLevel))
        else $error("alarm pin level wrong");
    gpo_level_a: assert property (gpo_cause_s
        |-> multiFunctionPinOe == ($past(bkSync_reg[1]) ? 1'b0 : !$past(ctrl_reg.level)))
        else $error("general purpose level wrong");
    sqw_backup_a: assert property (ctrl_reg.square_wave_enable && bkSync_reg == 2'h3 |=> !multiFunctionPinOe)
        else $error("square wave on backup");
endmodule // rtm_pin_trim_properties

bind rtm_pin_trim rtm_pin_trim_properties chk (.core_clk(core_clk), .reset_n(reset_n),
    .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regHit(regHit), .onBackupPin(onBackupPin), .alarm0MatchFlag(alarm0MatchFlag),
    .alarm1MatchFlag(alarm1MatchFlag), .alarmOutputPolarity(alarmOutputPolarity),
    .multiFunctionPinOut(multiFunctionPinOut), .multiFunctionPinOe(multiFunctionPinOe));

// [bench/rtm_host_model.sv]
// host side of the open-drain pin: pull-up resistor on the line
// assumes the device lets go of the line when its enable is low
`timescale 1ns/1ns
module rtm_host_model (
    // pin from the device
    input wire logic pinOut,
    input wire logic pinOe,
    // resolved line
    output logic pinLevel
);
    // pull-up wins whenever the device lets go
    assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule // rtm_host_model

// [bench/test_rtm_pin_trim.sv]
// self-checking bench for rtm_pin_trim behind a pulled-up host pin
// assumes a 50 MHz core clock; oscillator sped up to 1/8 core rate
`timescale 1ns/1ns
module test_rtm_pin_trim;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic onBackupPin = 1'b0;
    logic alarm0MatchFlag = 1'b0;
    logic alarm1MatchFlag = 1'b0;
    logic alarmOutputPolarity = 1'b0;
    logic [2:0] oscDiv = 3'h0;
    logic [7:0] regRdData;
    logic pinOut;
    logic pinOe;
    logic pinLevel;
    logic extClk;
    int n_fail = 0;
    int n_checks = 0;
    // real crystal rate would make a trim period too long to run
    wire logic oscClkPin = oscDiv[2];

    always #10 core_clk = ~core_clk;
    always @(negedge core_clk) oscDiv <= oscDiv + 3'h1;

    rtm_pin_trim uut (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regHit(), .oscClkPin(oscClkPin),
        .onBackupPin(onBackupPin), .alarm0MatchFlag(alarm0MatchFlag), .alarm1MatchFlag(alarm1MatchFlag),
        .alarmOutputPolarity(alarmOutputPolarity), .externalClockInput(extClk), .secondTick(), .minuteTick(),
        .multiFunctionPinOut(pinOut), .multiFunctionPinOe(pinOe));
    rtm_host_model host (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge core_clk);
        regWrite = 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        regAddr = a;
        repeat (2) @(negedge core_clk);
        check("read data", {8'h00, regRdData}, {8'h00, exp});
    endtask
    task automatic pinChk(input logic exp);
        repeat (5) @(negedge core_clk);
        check("pin level", {15'h0, pinLevel}, {15'h0, exp});
    endtask
    // third half period, so a fresh trim value has settled
    task automatic halfPeriod(input logic [15:0] exp);
        int n;
        logic last;
        repeat (3) begin
            last = pinLevel;
            n = 0;
            while (pinLevel === last && n < 20000) begin
                @(negedge core_clk);
                n++;
            end
        end
        check("half period", n[15:0], exp);
    endtask

    task automatic t_registers;
        rdChk(8'h07, 8'h80);
        rdChk(8'h08, 8'h00);
        rdChk(8'h09, 8'h00);
        pinChk(1'b1);
        wr(8'h08, 8'h8A);
        rdChk(8'h08, 8'h8A);
        wr(8'h07, 8'h00);
        onBackupPin = 1'b1;
        pinChk(1'b1);
        wr(8'h07, 8'h44);
        onBackupPin = 1'b0;
        rdChk(8'h07, 8'h00);
        wr(8'h07, 8'h08);
        @(negedge core_clk);
        check("external clock bit", {15'h0, extClk}, 16'h1);
        $display("test registers done");
    endtask
    task automatic t_alarm;
        logic any;
        logic all;
        for (int i = 0; i < 64; i++) begin
            wr(8'h07, {2'h0, i[1:0], 4'h0});
            alarm0MatchFlag = i[2];
            alarm1MatchFlag = i[3];
            alarmOutputPolarity = i[4];
            onBackupPin = i[5];
            any = (i[0] & i[2]) | (i[1] & i[3]);
            all = (!i[0] | i[2]) & (!i[1] | i[3]);
            pinChk(i[1:0] != 0 ? (i[4] ? any : !all) : i[5]);
            onBackupPin = 1'b0;
            // let the supply state leave the synchroniser before the next write
            repeat (4) @(negedge core_clk);
        end
        $display("test alarm done");
    endtask
    task automatic t_sqw;
        logic allHigh;
        logic [15:0] halfTab [1:3] = '{16'd32, 16'd16, 16'd4};
        allHigh = 1'b1;
        for (int r = 1; r < 4; r++) begin
            wr(8'h07, {6'h1C, 2'(r)});
            halfPeriod(halfTab[r]);
        end
        // coarse mode 64 Hz tap: prescaler has not yet set bit 8 here, so the pin holds low
        wr(8'h07, 8'h5C);
        repeat (5) @(negedge core_clk);
        allHigh = 1'b0;
        repeat (600) begin
            @(negedge core_clk);
            allHigh |= pinLevel;
        end
        check("slow square wave", {15'h0, allHigh}, 16'h0);
        allHigh = 1'b1;
        wr(8'h07, 8'h5F);
        onBackupPin = 1'b1;
        repeat (5) @(negedge core_clk);
        repeat (16) begin
            @(negedge core_clk);
            allHigh &= pinLevel;
        end
        check("backup square wave", {15'h0, allHigh}, 16'h1);
        onBackupPin = 1'b0;
        repeat (4) @(negedge core_clk);
        $display("test square wave done");
    endtask
    task automatic t_coarse;
        wr(8'h07, 8'h44);
        wr(8'h08, 8'h00);
        halfPeriod(16'd2048);
        wr(8'h08, 8'h85);
        halfPeriod(16'd1968);
        wr(8'h08, 8'h7F);
        halfPeriod(16'd4080);
        $display("test coarse trim done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        conclude;
    end
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        t_registers;
        t_alarm;
        t_sqw;
        t_coarse;
        conclude;
    end
endmodule // test_rtm_pin_trim
